/* File: hdl/shn_pkg.sv */
// Purpose: Constants for host-side serial link speed negotiation
// Assumes: 125 MHz mclk
// Notes:   Rate codes are a small enumeration shared with the PHY lanes
package shn_pkg;
  typedef enum logic [1:0] {
    SHN_RATE_GEN1 = 2'h1,
    SHN_RATE_GEN2 = 2'h2,
    SHN_RATE_GEN3 = 2'h3
  } shn_rate_t;

  typedef enum logic [1:0] {
    SHN_TX_TONE  = 2'h0,
    SHN_TX_ALIGN = 2'h1,
    SHN_TX_SYNC  = 2'h2
  } shn_tx_t;

  typedef enum logic [1:0] {
    SHN_ST_TONE  = 2'h0,
    SHN_ST_ALIGN = 2'h1,
    SHN_ST_IDLE  = 2'h3
  } shn_state_t;

  localparam int  SHN_CLK_MHZ       = 125;
  localparam int  SHN_ALIGN_HOLD    = 4;
  localparam logic [2:0] SHN_HOLD_W = 3'h4;
  localparam logic       SHN_SRC_REF20  = 1'b0;
  localparam logic       SHN_SRC_SERDES = 1'b1;
endpackage : shn_pkg

/* File: hdl/shn_speed_neg.sv */
// Purpose: Host end of link speed negotiation and PHY clock source select
// Assumes: Receive lane flags come from the PHY domain and are synchronised here
// Notes:   Tone is at GEN1; answers only at a detected GEN2/GEN1 rate
`timescale 1ns/10ps

// Summary of operation
// - After reset send continuous D10.2 tone at GEN1 until ALIGNp recognised.
// - Accept target ALIGNp only at GEN2 or GEN1; keep tone during GEN3.
// - On completion go to logical idle, sending SYNCp at negotiated rate.
// - PHY runs from 20 MHz and 1.5 GHz; 20 MHz from main reference.
// - 1.5 GHz source selectable: 20 MHz reference or 100 MHz SERDES input.
module shn_speed_neg
  import shn_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       rx_align_seen,
  input  wire logic [1:0] rx_align_rate,
  input  wire logic       rx_sync_seen,
  input  wire logic       rx_cominit,
  input  wire logic       pll_src_sel,
  output logic      [1:0] tx_kind,
  output logic      [1:0] tx_rate,
  output logic            link_up,
  output logic            ref20_from_main,
  output logic            pll_src_serdes
);

  logic [2:0] align_s;
  logic [2:0] com_s;
  logic [2:0] sync_s;
  logic [1:0] rate_s1;
  logic [1:0] rate_s2;
  logic [1:0] rate_s3;
  logic [2:0] src_s;
  shn_state_t state;
  shn_state_t next_state;
  logic [1:0] neg_rate;
  logic [1:0] next_neg_rate;
  logic [2:0] hold;

  function automatic logic agree(input logic a, input logic b);
    agree = a & b;
  endfunction : agree

  wire align_ok   = agree(align_s[1], align_s[2]) && (rate_s2 == rate_s3);
  wire rate_legal = (rate_s3 == SHN_RATE_GEN1) || (rate_s3 == SHN_RATE_GEN2);
  wire accept     = align_ok && rate_legal;
  wire cominit    = agree(com_s[1], com_s[2]);
  wire sync_ok    = agree(sync_s[1], sync_s[2]);
  wire src_ok     = (src_s[1] == src_s[2]);

  // Pin synchronisers, three stages
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      align_s <= 3'h0;
      com_s   <= 3'h0;
      sync_s  <= 3'h0;
      rate_s1 <= 2'h0;
      rate_s2 <= 2'h0;
      rate_s3 <= 2'h0;
      src_s   <= 3'h0;
    end else begin
      align_s <= {align_s[1:0], rx_align_seen};
      com_s   <= {com_s[1:0], rx_cominit};
      sync_s  <= {sync_s[1:0], rx_sync_seen};
      rate_s1 <= rx_align_rate;
      rate_s2 <= rate_s1;
      rate_s3 <= rate_s2;
      src_s   <= {src_s[1:0], pll_src_sel};
    end
  end

  always_comb begin
    next_state    = state;
    next_neg_rate = neg_rate;
    if (cominit) begin
      next_state    = SHN_ST_TONE;
      next_neg_rate = SHN_RATE_GEN1;
    end else begin
      unique case (state)
        SHN_ST_TONE: begin
          if (accept) begin
            next_state    = SHN_ST_ALIGN;
            next_neg_rate = rate_s3;
          end
        end
        SHN_ST_ALIGN: begin
          if (sync_ok || hold == SHN_HOLD_W) begin
            next_state = SHN_ST_IDLE;
          end
        end
        SHN_ST_IDLE: begin
          next_state = SHN_ST_IDLE;
        end
        default: begin
          next_state = SHN_ST_TONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= SHN_ST_TONE;
      neg_rate <= SHN_RATE_GEN1;
    end else begin
      state    <= next_state;
      neg_rate <= next_neg_rate;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 3'h0;
    end else if (state == SHN_ST_ALIGN && align_ok && rate_s3 == neg_rate && hold != SHN_HOLD_W) begin
      hold <= hold + 3'h1;
    end else if (state != SHN_ST_ALIGN) begin
      hold <= 3'h0;
    end
  end

  wire [1:0] next_kind = (next_state == SHN_ST_TONE)  ? SHN_TX_TONE :
                         (next_state == SHN_ST_ALIGN) ? SHN_TX_ALIGN : SHN_TX_SYNC;
  wire [1:0] next_rate = (next_state == SHN_ST_TONE) ? SHN_RATE_GEN1 : next_neg_rate;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_kind         <= SHN_TX_TONE;
      tx_rate         <= SHN_RATE_GEN1;
      link_up         <= 1'b0;
      ref20_from_main <= 1'b1;
      pll_src_serdes  <= SHN_SRC_REF20;
    end else begin
      tx_kind         <= next_kind;
      tx_rate         <= next_rate;
      link_up         <= (next_state == SHN_ST_IDLE);
      ref20_from_main <= 1'b1;
      if (src_ok && state == SHN_ST_TONE) begin
        pll_src_serdes <= src_s[2];
      end
    end
  end

  no_gen3_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_kind == SHN_TX_ALIGN |-> tx_rate != SHN_RATE_GEN3)
    else $error("align answered at GEN3");
  tone_gen1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_kind == SHN_TX_TONE |-> tx_rate == SHN_RATE_GEN1)
    else $error("tone not at GEN1");
  tone_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == SHN_ST_TONE && !accept && !cominit) |=> tx_kind == SHN_TX_TONE)
    else $error("tone left without alignment");
  answer_rate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == SHN_ST_TONE && accept && !cominit) |=> tx_kind == SHN_TX_ALIGN && tx_rate == $past(rate_s3))
    else $error("answer rate mismatch");
  idle_sync_a: assert property (@(posedge mclk) disable iff (!rst_n)
    link_up |-> tx_kind == SHN_TX_SYNC && tx_rate == neg_rate)
    else $error("idle not sending sync");
  rate_stable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_kind != SHN_TX_TONE && $past(tx_kind) != SHN_TX_TONE) |-> $stable(tx_rate))
    else $error("rate changed after answer");
  restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cominit |=> tx_kind == SHN_TX_TONE && !link_up)
    else $error("reset request ignored");
  ref20_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ref20_from_main)
    else $error("20 MHz not from main reference");
  src_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state != SHN_ST_TONE |=> $stable(pll_src_serdes))
    else $error("clock source moved during link");

  // Sequencing checks
  gen3_tone_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == SHN_ST_TONE && align_ok && rate_s3 == SHN_RATE_GEN3 && !cominit) |=> tx_kind == SHN_TX_TONE)
    else $error("GEN3 alignment left the tone");
  answer_legal_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_kind == SHN_TX_ALIGN && $past(tx_kind) == SHN_TX_TONE) |-> $past(accept))
    else $error("answer without accepted alignment");
  answer_neg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_kind == SHN_TX_ALIGN |-> tx_rate == neg_rate)
    else $error("answer off the negotiated rate");
  sync_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == SHN_ST_ALIGN && sync_ok && !cominit) |=> link_up && tx_kind == SHN_TX_SYNC)
    else $error("sync seen but idle not entered");
  hold_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == SHN_ST_ALIGN && hold == SHN_HOLD_W && !cominit) |=> link_up)
    else $error("matching align count did not finish");
  hold_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state != SHN_ST_ALIGN |=> hold == 3'h0)
    else $error("align count not cleared");
  idle_stays_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (link_up && !cominit) |=> link_up && $stable(tx_rate))
    else $error("idle left without reset request");
  idle_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (link_up && !$past(link_up)) |-> $past(tx_kind) == SHN_TX_ALIGN)
    else $error("idle entered without answer");
  restart_rate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cominit |=> tx_rate == SHN_RATE_GEN1)
    else $error("restart tone not at GEN1");
  tone_no_link_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_kind == SHN_TX_TONE |-> !link_up)
    else $error("link up while sending tone");
  src_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == SHN_ST_TONE && src_ok) |=> pll_src_serdes == $past(src_s[2]))
    else $error("clock source select not taken");

  gen2_link_c: cover property (@(posedge mclk) disable iff (!rst_n)
    link_up && tx_rate == SHN_RATE_GEN2);
  gen1_link_c: cover property (@(posedge mclk) disable iff (!rst_n)
    link_up && tx_rate == SHN_RATE_GEN1);
  gen3_ignored_c: cover property (@(posedge mclk) disable iff (!rst_n)
    align_ok && rate_s3 == SHN_RATE_GEN3 ##1 tx_kind == SHN_TX_TONE);
  restart_c: cover property (@(posedge mclk) disable iff (!rst_n)
    link_up ##1 cominit);
  hold_done_c: cover property (@(posedge mclk) disable iff (!rst_n)
    state == SHN_ST_ALIGN && hold == SHN_HOLD_W);

endmodule : shn_speed_neg

/* File: verification/shn_target_model.sv */
// Purpose: Attached target drive model for speed negotiation
// Assumes: Short per-rate timeout in mclk cycles
// Notes:   deaf makes the target ignore host replies
`timescale 1ns/10ps
module shn_target_model
  import shn_pkg::*;
#(
  parameter int TMO = 20
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic       deaf,
  input  wire logic [1:0] top,
  input  wire logic [1:0] tx_kind,
  input  wire logic [1:0] tx_rate,
  output logic            rx_align_seen,
  output logic      [1:0] rx_align_rate,
  output logic            rx_sync_seen,
  output logic            rx_cominit
);
  logic [1:0] rate;
  int         cnt;
  // Rate lines carry no stale value when no ALIGNp is sent
  assign rx_align_rate = rx_align_seen ? rate : ~rate;
  always @(negedge mclk or negedge rst_n) begin
    if (!rst_n || !go) begin
      rate          <= top;
      cnt           <= 0;
      rx_align_seen <= 1'b0;
      rx_sync_seen  <= 1'b0;
      rx_cominit    <= 1'b0;
    end else if (!deaf && rx_align_seen && tx_kind == SHN_TX_ALIGN && tx_rate == rate) begin
      rx_sync_seen  <= 1'b1;
      rx_align_seen <= 1'b0;
    end else if (rx_sync_seen || rx_cominit) begin
      cnt <= cnt;
    end else if (cnt == TMO) begin
      cnt           <= 0;
      rx_align_seen <= 1'b0;
      rx_cominit    <= (rate == SHN_RATE_GEN1);
      rate          <= rate - 2'h1;
    end else begin
      cnt           <= cnt + 1;
      rx_align_seen <= 1'b1;
    end
  end
endmodule : shn_target_model

/* File: verification/sata_host_speed_negotiation_test.sv */
// Purpose: Self-checking bench for host speed negotiation
// Assumes: Target model drives the receive flags
// Notes:   Row fields are target top rate, source select, agreed rate
`timescale 1ns/10ps
module sata_host_speed_negotiation_test;
  import shn_pkg::*;
  logic       mclk, rst_n, go, deaf, sel, seen, sync_s, cominit, link_up, ref20, serdes;
  logic [1:0] top, rate, kind, txr;
  int         failures, total_checks, bad, wrong, n, i;
  logic [5:0] rows [3] = '{6'h36, 6'h22, 6'h15};
  shn_speed_neg shn_speed_neg_inst (.mclk(mclk), .rst_n(rst_n), .rx_align_seen(seen), .rx_align_rate(rate),
    .rx_sync_seen(sync_s), .rx_cominit(cominit), .pll_src_sel(sel), .tx_kind(kind), .tx_rate(txr),
    .link_up(link_up), .ref20_from_main(ref20), .pll_src_serdes(serdes));
  shn_target_model shn_target_model_inst (.mclk(mclk), .rst_n(rst_n), .go(go), .deaf(deaf), .top(top),
    .tx_kind(kind), .tx_rate(txr), .rx_align_seen(seen), .rx_align_rate(rate), .rx_sync_seen(sync_s),
    .rx_cominit(cominit));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic do_reset();
    rst_n = 1'b0;
    go    = 1'b0;
    repeat (4) @(negedge mclk);
    chk("kind", kind, SHN_TX_TONE);
    chk("rate", txr, SHN_RATE_GEN1);
    chk("ref20", {1'b0, ref20}, 2'h1);
    chk("serdes", {1'b0, serdes}, 2'h0);
    rst_n = 1'b1;
  endtask : do_reset
  // Runs until link up or COMINIT, counting any GEN3 answer
  task automatic run(input logic on_cominit, input logic [1:0] exp);
    n = 0;
    while (((on_cominit ? cominit : link_up) !== 1'b1) && n < 300) begin
      @(negedge mclk);
      n++;
      if (kind === SHN_TX_ALIGN && txr === SHN_RATE_GEN3) bad++;
      if (kind === SHN_TX_ALIGN && txr !== exp) wrong++;
    end
    if ((on_cominit ? cominit : link_up) !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask : run
  initial begin
    failures     = 0;
    total_checks = 0;
    bad          = 0;
    wrong        = 0;
    {rst_n, go, deaf, sel, top} = 6'h03;
    for (i = 0; i < 3; i++) begin
      top = rows[i][5:4];
      do_reset();
      sel = rows[i][2];
      repeat (6) @(negedge mclk);
      chk("serdes", {1'b0, serdes}, {1'b0, sel});
      go = 1'b1;
      run(1'b0, rows[i][1:0]);
      repeat (6) @(negedge mclk);
      chk("kind", kind, SHN_TX_SYNC);
      chk("ref20", {1'b0, ref20}, 2'h1);
      chk("rate", txr, rows[i][1:0]);
      chk("link", {1'b0, link_up}, 2'h1);
      sel = ~sel;
      repeat (6) @(negedge mclk);
      chk("hold", {1'b0, serdes}, {1'b0, ~sel});
    end
    chk("gen3", {1'b0, bad != 0}, 2'h0);
    top  = SHN_RATE_GEN3;
    deaf = 1'b1;
    do_reset();
    go = 1'b1;
    run(1'b1, SHN_RATE_GEN2);
    repeat (6) @(negedge mclk);
    chk("answer", {1'b0, wrong != 0}, 2'h0);
    chk("kind", kind, SHN_TX_TONE);
    chk("link", {1'b0, link_up}, 2'h0);
    summarize();
  end
endmodule : sata_host_speed_negotiation_test
